// file: logic/atahd_pkg.sv
// package for the task-file access decoder: offsets, mapping indices, i/o bases
// assumes a single 200 MHz system clock domain
package atahd_pkg;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_FAULT = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_BLK_LO = 4'h3;
  localparam logic [3:0] OFS_BLK_MID = 4'h4;
  localparam logic [3:0] OFS_BLK_HI = 4'h5;
  localparam logic [3:0] OFS_UNIT = 4'h6;
  localparam logic [3:0] OFS_STATE = 4'h7;
  localparam logic [3:0] OFS_DATA_DUP = 4'h8;
  localparam logic [3:0] OFS_ODD_DUP = 4'h9;
  localparam logic [3:0] OFS_FAULT_DUP = 4'hd;
  localparam logic [3:0] OFS_SHADOW = 4'he;
  localparam logic [3:0] OFS_UNIT_RB = 4'hf;
  localparam logic [3:0] OFS_DISK_SHADOW = 4'h6;
  localparam logic [5:0] MAP_MEMORY = 6'h00;
  localparam logic [5:0] MAP_CONTIG = 6'h01;
  localparam logic [5:0] MAP_PRIMARY = 6'h02;
  localparam logic [5:0] MAP_SECONDARY = 6'h03;
  localparam logic [5:0] MAP_RESET = 6'h00;
  localparam logic [5:0] PRI_CMD_BASE = 6'h1f;
  localparam logic [5:0] PRI_CTL_BASE = 6'h3f;
  localparam logic [5:0] SEC_CMD_BASE = 6'h17;
  localparam logic [5:0] SEC_CTL_BASE = 6'h37;
  localparam int unsigned MEM_REG_SPAN = 2048;
  localparam int unsigned MEM_WIN_BASE = 1024;
  localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
  localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
  localparam logic [7:0] UNIT_RESET = 8'ha0;
  localparam logic [7:0] SHADOW_CTL_RESET = 8'h00;
endpackage

// file: logic/atahd_decoder.sv
// host-socket access decoder: byte/word lanes onto task file and data buffer
// assumes strobes already synchronous to clk_sys; one access per strobe edge
`timescale 1ns/1ps
module atahd_decoder
  import atahd_pkg::*;
#(
  parameter int unsigned BUF_WORDS = 256,
  parameter int unsigned AW = 11
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic power_up, // power-up pulse, distinguishes from hard reset
  input wire logic ce1_n, // lower byte enable
  input wire logic ce2_n, // upper byte enable
  input wire logic reg_n, // attribute/io select, low = io
  input wire logic [AW-1:0] addr, // host address
  input wire logic oe_n, // memory read strobe, also disk mode strap
  input wire logic we_n, // memory write strobe
  input wire logic iord_n, // io read strobe
  input wire logic iowr_n, // io write strobe
  input wire logic [5:0] mapping_selector_bits, // configuration index
  input wire logic [15:0] d_in, // data bus in
  output logic [15:0] d_out, // data bus out
  output logic d_lo_oe, // lower lane drive
  output logic d_hi_oe, // upper lane drive
  output logic dedicated_disk_mode, // disk mode latched at power-up
  output logic [7:0] fault_info_q, // error register contents
  output logic [7:0] option_select_q, // last features value
  output logic [7:0] opcode_q, // last command written
  output logic opcode_stb, // one-cycle pulse on command write
  output logic [7:0] iface_ctl_q, // device control
  output logic [7:0] blk_count_q, // transfer block count
  output logic [23:0] start_block_q, // start block low/mid/high
  output logic [7:0] unit_sel_q, // unit and top block select
  output logic [$clog2(BUF_WORDS)-1:0] buf_ptr_q, // buffer word pointer
  output logic byte_phase_q // next byte is odd
);
  import atahd_pkg::*;

  localparam int unsigned PW = $clog2(BUF_WORDS);

  logic [15:0] buf_mem [BUF_WORDS];
  logic rd_q;
  logic wr_q;
  logic rd_st;
  logic wr_st;
  logic rd_go;
  logic wr_go;
  logic mem_cyc;
  logic io_cyc;
  logic hit;
  logic [3:0] ofs;
  logic eight_bit_q, pwr_seen_q;
  logic [7:0] state_q, unit_rb_q;
  logic is_data;
  logic is_odd;
  logic is_fault;
  logic word_acc;
  logic lo_only;
  logic hi_only;
  logic both_lo;
  logic tf_wr;
  logic [5:0] idx;

  assign idx = mapping_selector_bits;
  assign rd_st = dedicated_disk_mode || !mem_cyc ? !iord_n : !oe_n;
  assign wr_st = dedicated_disk_mode || !mem_cyc ? !iowr_n : !we_n;
  assign rd_go = rd_st && !rd_q && hit;
  assign wr_go = wr_st && !wr_q && hit;
  assign both_lo = !ce1_n && !ce2_n;
  // disk mode data port is word wide on the lower enable until 8-bit mode is on
  assign word_acc = dedicated_disk_mode ? (lo_only && addr[2:0] == 3'h0 && !eight_bit_q)
    : both_lo;
  assign lo_only = !ce1_n && ce2_n;
  assign hi_only = ce1_n && !ce2_n;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_st;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr_st;
    end
  end

  // strap sampled only on power-up; a plain reset (hot insert) clears it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwr_seen_q <= 1'b0;
      dedicated_disk_mode <= 1'b0;
    end else if (power_up && !pwr_seen_q) begin
      pwr_seen_q <= 1'b1;
      dedicated_disk_mode <= !oe_n;
    end else if (!power_up) begin
      pwr_seen_q <= 1'b0;
    end
  end

  // address decode per mapping
  always_comb begin
    mem_cyc = 1'b0;
    io_cyc = 1'b0;
    hit = 1'b0;
    ofs = addr[3:0];
    if (ce1_n && ce2_n) begin
      hit = 1'b0;
    end else if (dedicated_disk_mode) begin
      io_cyc = 1'b1;
      ofs = {1'b0, addr[2:0]};
      if (lo_only) begin
        hit = 1'b1;
      end else if (hi_only && addr[2:0] == OFS_DISK_SHADOW[2:0]) begin
        hit = 1'b1;
        ofs = addr[0] ? OFS_UNIT_RB : OFS_SHADOW;
      end
    end else if (idx == MAP_MEMORY) begin
      mem_cyc = reg_n;
      hit = reg_n && 32'(addr) < MEM_REG_SPAN;
      if (32'(addr) >= MEM_WIN_BASE) begin
        ofs = addr[0] ? OFS_ODD_DUP : OFS_DATA_DUP;
      end
    end else if (!reg_n) begin
      io_cyc = 1'b1;
      unique case (idx)
        MAP_CONTIG: hit = 1'b1;
        MAP_PRIMARY: hit = (addr[9:4] == PRI_CMD_BASE && !addr[3])
          || (addr[9:4] == PRI_CTL_BASE && addr[3:1] == 3'h3);
        MAP_SECONDARY: hit = (addr[9:4] == SEC_CMD_BASE && !addr[3])
          || (addr[9:4] == SEC_CTL_BASE && addr[3:1] == 3'h3);
        default: hit = 1'b0;
      endcase
      if (hit && (idx == MAP_PRIMARY || idx == MAP_SECONDARY) && addr[9:4] != PRI_CMD_BASE
          && addr[9:4] != SEC_CMD_BASE) begin
        ofs = addr[0] ? OFS_UNIT_RB : OFS_SHADOW;
      end
    end
  end

  // classify the target register
  always_comb begin
    is_data = 1'b0;
    is_odd = 1'b0;
    is_fault = 1'b0;
    if (ofs == OFS_DATA || ofs == OFS_DATA_DUP || ofs == OFS_ODD_DUP) begin
      if (word_acc) begin
        is_data = 1'b1;
      end else if (ofs == OFS_DATA && hi_only && !dedicated_disk_mode) begin
        is_fault = 1'b1;
      end else begin
        is_data = 1'b1;
        is_odd = ofs == OFS_ODD_DUP || hi_only;
      end
    end else if (ofs == OFS_FAULT || ofs == OFS_FAULT_DUP) begin
      is_fault = !word_acc || ofs == OFS_FAULT_DUP;
      is_data = word_acc && ofs == OFS_FAULT; // overlapped offset 1 word acts as data
    end
  end

  // data buffer pointer and byte phase
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buf_ptr_q <= '0;
      byte_phase_q <= 1'b0;
    end else if ((rd_go || wr_go) && is_data) begin
      if (word_acc) begin
        buf_ptr_q <= buf_ptr_q + PW'(1);
        byte_phase_q <= 1'b0;
      end else if (dedicated_disk_mode && !eight_bit_q) begin
        byte_phase_q <= byte_phase_q;
      end else if (is_odd || byte_phase_q) begin
        buf_ptr_q <= buf_ptr_q + PW'(1);
        byte_phase_q <= 1'b0;
      end else begin
        byte_phase_q <= 1'b1;
      end
    end
  end

  // odd first (9 then 8) ends the word on the odd byte; 8 then opens the next word
  always_ff @(posedge clk_sys) begin
    if (wr_go && is_data) begin
      if (word_acc) begin
        buf_mem[buf_ptr_q] <= d_in;
      end else if (!(dedicated_disk_mode && !eight_bit_q)) begin
        if (is_odd) begin
          buf_mem[buf_ptr_q][15:8] <= hi_only ? d_in[15:8] : d_in[7:0];
        end else if (byte_phase_q) begin
          buf_mem[buf_ptr_q][15:8] <= d_in[7:0];
        end else begin
          buf_mem[buf_ptr_q][7:0] <= d_in[7:0];
        end
      end
    end
  end

  // task file registers, one process each except the three start block bytes, which share one
  assign tf_wr = wr_go && !is_data && !is_fault;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      option_select_q <= '0;
    end else if (wr_go && is_fault) begin
      option_select_q <= hi_only || word_acc ? d_in[15:8] : d_in[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      blk_count_q <= '0;
    end else if (tf_wr && ofs == OFS_COUNT) begin
      blk_count_q <= d_in[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      start_block_q <= '0;
    end else if (tf_wr && ofs == OFS_BLK_LO) begin
      start_block_q[7:0] <= d_in[7:0];
    end else if (tf_wr && ofs == OFS_BLK_MID) begin
      start_block_q[15:8] <= d_in[7:0];
    end else if (tf_wr && ofs == OFS_BLK_HI) begin
      start_block_q[23:16] <= d_in[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      unit_sel_q <= UNIT_RESET;
    end else if (tf_wr && ofs == OFS_UNIT) begin
      unit_sel_q <= d_in[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      opcode_q <= '0;
      opcode_stb <= 1'b0;
    end else begin
      opcode_stb <= tf_wr && ofs == OFS_STATE;
      if (tf_wr && ofs == OFS_STATE) begin
        opcode_q <= d_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      eight_bit_q <= 1'b0;
    end else if (tf_wr && ofs == OFS_STATE && d_in[7:0] == CMD_SET_FEATURES) begin
      if (option_select_q == FEAT_8BIT_ON) begin
        eight_bit_q <= 1'b1;
      end else if (option_select_q == FEAT_8BIT_OFF) begin
        eight_bit_q <= 1'b0;
      end
    end
  end

  // disk mode takes control on the lower lane even with the upper enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      iface_ctl_q <= SHADOW_CTL_RESET;
    end else if (tf_wr && ofs == OFS_SHADOW) begin
      iface_ctl_q <= hi_only && !dedicated_disk_mode ? d_in[15:8] : d_in[7:0];
    end
  end

  // fixed ready pattern: no media engine stands behind this port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= {1'b0, 1'b1, 2'b01, 1'b1, 3'b000};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      unit_rb_q <= '0;
    end else begin
      unit_rb_q <= {2'b11, ~unit_sel_q[3:0], 1'b1, ~unit_sel_q[4]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_info_q <= '0;
    end else begin
      fault_info_q <= fault_info_q;
    end
  end

  // read data and lane drive, registered
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (is_fault) begin
      rd_byte = fault_info_q;
    end else if (is_data) begin
      rd_byte = is_odd || byte_phase_q ? buf_mem[buf_ptr_q][15:8] : buf_mem[buf_ptr_q][7:0];
    end else begin
      unique case (ofs)
        OFS_COUNT: rd_byte = blk_count_q;
        OFS_BLK_LO: rd_byte = start_block_q[7:0];
        OFS_BLK_MID: rd_byte = start_block_q[15:8];
        OFS_BLK_HI: rd_byte = start_block_q[23:16];
        OFS_UNIT: rd_byte = unit_sel_q;
        OFS_STATE, OFS_SHADOW: rd_byte = state_q;
        OFS_UNIT_RB: rd_byte = unit_rb_q;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      d_out <= '0;
    end else if (rd_go) begin
      if (word_acc && is_data) begin
        d_out <= buf_mem[buf_ptr_q];
      end else if (word_acc) begin
        d_out <= {fault_info_q, rd_byte};
      end else begin
        d_out <= {rd_byte, rd_byte};
      end
    end
  end

  // disk mode answers on the lower lane; upper lane only for word data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      d_lo_oe <= 1'b0;
      d_hi_oe <= 1'b0;
    end else if (rd_go) begin
      d_lo_oe <= dedicated_disk_mode || !ce1_n;
      d_hi_oe <= dedicated_disk_mode ? word_acc : !ce2_n;
    end else if (!rd_st || (ce1_n && ce2_n)) begin
      d_lo_oe <= 1'b0;
      d_hi_oe <= 1'b0;
    end
  end
endmodule

// file: sim/atahd_decoder_monitor.sv
// checker for the task-file access decoder, watching its ports only
// assumes one clock domain and host strobes held until the answer edge
`timescale 1ns/1ps
module atahd_decoder_monitor #(
  parameter int unsigned BUF_WORDS = 256
) (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic ce1_n, // lower enable
  input wire logic ce2_n, // upper enable
  input wire logic reg_n, // io select
  input wire logic [10:0] addr, // address
  input wire logic oe_n, // mem read
  input wire logic we_n, // mem write
  input wire logic iowr_n, // io write
  input wire logic [5:0] mapping_selector_bits, // index
  input wire logic [15:0] d_in, // write data
  input wire logic d_lo_oe, // lower drive
  input wire logic d_hi_oe, // upper drive
  input wire logic dedicated_disk_mode, // disk mode
  input wire logic [7:0] option_select_q, // features
  input wire logic [7:0] blk_count_q, // count
  input wire logic [23:0] start_block_q, // start block
  input wire logic [$clog2(BUF_WORDS)-1:0] buf_ptr_q, // pointer
  input wire logic byte_phase_q // odd next
);
  wire logic mem_c = reg_n && mapping_selector_bits == 6'h00 && !dedicated_disk_mode;
  wire logic word_c = mem_c && !ce1_n && !ce2_n && !oe_n;
  wire logic byte_c = mem_c && !ce1_n && ce2_n && !oe_n;
  wire logic upper_c = mem_c && ce1_n && !ce2_n && !oe_n;
  wire logic invalid_c = dedicated_disk_mode && !ce1_n && !ce2_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence word_held; word_c ##1 word_c; endsequence
  sequence upper_held; upper_c ##1 upper_c; endsequence
  a_standby_float: assert property ($past(ce1_n && ce2_n) && ce1_n && ce2_n
    |-> !d_lo_oe && !d_hi_oe) else $error("lanes driven in standby");
  a_word_lanes: assert property (word_held |-> d_lo_oe && d_hi_oe)
    else $error("word read not on both lanes");
  a_upper_lane: assert property (upper_held |-> !d_lo_oe && d_hi_oe)
    else $error("upper byte read lanes wrong");
  a_disk_invalid: assert property (invalid_c ##1 invalid_c |-> !d_lo_oe && !d_hi_oe)
    else $error("both enables driven in disk mode");
  a_word_step: assert property (word_c && $fell(oe_n)
    && (addr[10] || addr[3:0] inside {4'h0, 4'h1, 4'h8, 4'h9})
    |=> buf_ptr_q == $past(buf_ptr_q) + 1'b1) else $error("word did not step pointer");
  a_byte_phase: assert property (byte_c && $fell(oe_n) && addr == 11'h000
    |=> byte_phase_q != $past(byte_phase_q)) else $error("byte phase did not toggle");
  a_window_odd: assert property (byte_c && $fell(oe_n) && addr[10] && addr[0] && byte_phase_q
    |=> buf_ptr_q == $past(buf_ptr_q) + 1'b1 && !byte_phase_q)
    else $error("odd window byte did not end word");
  a_upper_hold: assert property (upper_c && $fell(oe_n) && addr == 11'h000
    |=> $stable(buf_ptr_q) && $stable(byte_phase_q)) else $error("upper byte moved buffer");
  a_feature_wr: assert property ($fell(we_n) && mem_c && ce1_n && !ce2_n && addr == 11'h000
    |=> option_select_q == $past(d_in[15:8])) else $error("features not written");
  a_contig_wr: assert property ($fell(iowr_n) && !reg_n && mapping_selector_bits == 6'h01
    && !dedicated_disk_mode && !ce1_n && ce2_n && addr[3:0] == 4'h3
    |=> start_block_q[7:0] == $past(d_in[7:0])) else $error("contiguous block write lost");
  a_disk_no_mem: assert property (dedicated_disk_mode && reg_n && $fell(we_n)
    |=> $stable(blk_count_q) && $stable(start_block_q)) else $error("memory write in disk mode");
endmodule

// file: sim/atahd_host.sv
// host socket model: enables, strobes, address, write data, power strap
// assumes the decoder takes a strobe fall and answers one edge later
`timescale 1ns/1ps
module atahd_host (
  input wire logic clk_sys, // clock
  output logic power_up, // power phase
  output logic ce1_n, // lower enable
  output logic ce2_n, // upper enable
  output logic reg_n, // io select
  output logic [10:0] addr, // address
  output logic oe_n, // mem read
  output logic we_n, // mem write
  output logic iord_n, // io read
  output logic iowr_n, // io write
  output logic [15:0] d_in // write data
);
  initial begin
    {power_up, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n} = 8'h7f;
    addr = 11'h000;
    d_in = 16'h0000;
  end
  task automatic power_on(input logic disk);
    @(posedge clk_sys) #1;
    power_up = 1'b1;
    oe_n = !disk;
    repeat (2) @(posedge clk_sys);
    #1;
    power_up = 1'b0;
    oe_n = 1'b1;
  endtask
  // never two byte accesses at offset 9 in a row
  task automatic acc(input logic io, input logic wr, input logic [1:0] ce_n,
      input logic [10:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    {ce2_n, ce1_n} = ce_n;
    reg_n = !io;
    addr = a;
    d_in = wr ? d : ~d;
    oe_n = io || wr;
    we_n = io || !wr;
    iord_n = !io || wr;
    iowr_n = !io || !wr;
    repeat (2) @(posedge clk_sys);
    #1;
    {ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n} = 6'h3f;
    d_in = ~d_in; // released bus shows no stale value
  endtask
endmodule

// file: sim/atahd_decoder_tb.sv
// testbench for the task-file access decoder
// assumes host model tasks hold strobes until the answer edge
`timescale 1ns/1ps
module atahd_decoder_tb;
  import atahd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] msel = MAP_MEMORY;
  logic power_up, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n;
  logic [10:0] addr;
  logic [15:0] d_in, d_out;
  logic d_lo_oe, d_hi_oe, dedicated_disk_mode, opcode_stb, byte_phase_q;
  logic [7:0] fault_info_q, option_select_q, opcode_q, iface_ctl_q, blk_count_q, unit_sel_q;
  logic [23:0] start_block_q;
  logic [7:0] buf_ptr_q, p;
  int errors = 0;
  int compares = 0;
  int stb_cnt = 0;
  always @(posedge clk_sys) if (opcode_stb === 1'b1) stb_cnt++;
  always #2.5 clk_sys = ~clk_sys;
  atahd_host atahd_host_i (.clk_sys(clk_sys), .power_up(power_up), .ce1_n(ce1_n),
    .ce2_n(ce2_n), .reg_n(reg_n), .addr(addr), .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n),
    .iowr_n(iowr_n), .d_in(d_in));
  atahd_decoder #(.BUF_WORDS(256), .AW(11)) atahd_decoder_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .power_up(power_up), .ce1_n(ce1_n), .ce2_n(ce2_n), .reg_n(reg_n),
    .addr(addr), .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n),
    .mapping_selector_bits(msel), .d_in(d_in), .d_out(d_out), .d_lo_oe(d_lo_oe),
    .d_hi_oe(d_hi_oe), .dedicated_disk_mode(dedicated_disk_mode), .fault_info_q(fault_info_q),
    .option_select_q(option_select_q), .opcode_q(opcode_q), .opcode_stb(opcode_stb),
    .iface_ctl_q(iface_ctl_q), .blk_count_q(blk_count_q), .start_block_q(start_block_q),
    .unit_sel_q(unit_sel_q), .buf_ptr_q(buf_ptr_q), .byte_phase_q(byte_phase_q));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_maps;
    check(unit_sel_q, UNIT_RESET);
    check(dedicated_disk_mode, 1'b0);
    atahd_host_i.acc(1'b0, 1'b1, 2'b10, 11'h002, 16'h0033);
    check(blk_count_q, 8'h33);
    msel = MAP_CONTIG;
    atahd_host_i.acc(1'b1, 1'b1, 2'b10, 11'h7a3, 16'h0044);
    check(start_block_q[7:0], 8'h44);
    msel = MAP_PRIMARY;
    atahd_host_i.acc(1'b1, 1'b1, 2'b10, 11'h175, 16'h0055);
    check(start_block_q[23:16], 8'h00);
    atahd_host_i.acc(1'b1, 1'b1, 2'b10, 11'h1f4, 16'h0066);
    check(start_block_q[15:8], 8'h66);
    msel = MAP_SECONDARY;
    atahd_host_i.acc(1'b1, 1'b1, 2'b10, 11'h175, 16'h0077);
    check(start_block_q[23:16], 8'h77);
    msel = MAP_MEMORY;
  endtask
  task automatic t_words;
    p = buf_ptr_q;
    atahd_host_i.acc(1'b0, 1'b0, 2'b00, 11'h001, 16'h0000);
    check({d_lo_oe, d_hi_oe}, 2'b11);
    atahd_host_i.acc(1'b0, 1'b0, 2'b00, 11'h008, 16'h0000);
    atahd_host_i.acc(1'b0, 1'b0, 2'b00, 11'h009, 16'h0000);
    check(buf_ptr_q, p + 8'h03);
  endtask
  task automatic t_bytes;
    p = buf_ptr_q;
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h000, 16'h0000);
    check({d_lo_oe, d_hi_oe, byte_phase_q, buf_ptr_q}, {3'b101, p});
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h000, 16'h0000);
    check({byte_phase_q, buf_ptr_q}, {1'b0, p + 8'h01});
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h008, 16'h0000);
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h009, 16'h0000);
    check(buf_ptr_q, p + 8'h02);
    atahd_host_i.acc(1'b0, 1'b0, 2'b01, 11'h000, 16'h0000);
    check({d_lo_oe, d_hi_oe, buf_ptr_q}, {2'b01, p + 8'h02});
    atahd_host_i.acc(1'b0, 1'b1, 2'b01, 11'h000, 16'h5a00);
    check(option_select_q, 8'h5a);
  endtask
  task automatic t_window;
    p = buf_ptr_q;
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h400, 16'h0000);
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h7ff, 16'h0000);
    check(buf_ptr_q, p + 8'h01);
    atahd_host_i.acc(1'b0, 1'b0, 2'b00, 11'h5a6, 16'h0000);
    check(buf_ptr_q, p + 8'h02);
    atahd_host_i.acc(1'b0, 1'b0, 2'b11, 11'h000, 16'h0000);
    check({d_lo_oe, d_hi_oe}, 2'b00);
  endtask
  task automatic t_disk;
    atahd_host_i.power_on(1'b1);
    check(dedicated_disk_mode, 1'b1);
    atahd_host_i.acc(1'b0, 1'b1, 2'b10, 11'h002, 16'h0011);
    check(blk_count_q, 8'h33);
    atahd_host_i.acc(1'b1, 1'b1, 2'b10, 11'h002, 16'h0022);
    check(blk_count_q, 8'h22);
    atahd_host_i.acc(1'b1, 1'b0, 2'b00, 11'h000, 16'h0000);
    check({d_lo_oe, d_hi_oe}, 2'b00);
    atahd_host_i.acc(1'b1, 1'b1, 2'b01, 11'h006, 16'h0099);
    check(iface_ctl_q, 8'h99);
    atahd_host_i.acc(1'b1, 1'b0, 2'b10, 11'h000, 16'h0000);
    check({d_lo_oe, d_hi_oe}, 2'b11);
  endtask
  task automatic pulse_reset;
    @(posedge clk_sys) #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
  endtask
  task automatic t_data;
    pulse_reset();
    check(dedicated_disk_mode, 1'b0);
    atahd_host_i.acc(1'b0, 1'b1, 2'b00, 11'h000, 16'h1234);
    atahd_host_i.acc(1'b0, 1'b1, 2'b10, 11'h000, 16'h0056);
    atahd_host_i.acc(1'b0, 1'b1, 2'b10, 11'h000, 16'h0078);
    atahd_host_i.acc(1'b0, 1'b1, 2'b10, 11'h007, 16'h00ef);
    check({opcode_q, stb_cnt[7:0]}, {8'hef, 8'h01});
    pulse_reset();
    atahd_host_i.acc(1'b0, 1'b0, 2'b00, 11'h000, 16'h0000);
    check(d_out, 16'h1234);
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h000, 16'h0000);
    check(d_out[7:0], 8'h56);
    atahd_host_i.acc(1'b0, 1'b0, 2'b10, 11'h000, 16'h0000);
    check(d_out[7:0], 8'h78);
    atahd_host_i.acc(1'b0, 1'b0, 2'b01, 11'h000, 16'h0000);
    check({d_out[15:8], fault_info_q}, 16'h0000);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_maps();
    t_words();
    t_bytes();
    t_window();
    t_disk();
    t_data();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    test_done();
  end
endmodule
bind atahd_decoder atahd_decoder_monitor #(.BUF_WORDS(BUF_WORDS)) mon_i (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .ce1_n(ce1_n), .ce2_n(ce2_n), .reg_n(reg_n), .addr(addr), .oe_n(oe_n),
  .we_n(we_n), .iowr_n(iowr_n), .mapping_selector_bits(mapping_selector_bits), .d_in(d_in),
  .d_lo_oe(d_lo_oe), .d_hi_oe(d_hi_oe), .dedicated_disk_mode(dedicated_disk_mode),
  .option_select_q(option_select_q), .blk_count_q(blk_count_q),
  .start_block_q(start_block_q), .buf_ptr_q(buf_ptr_q), .byte_phase_q(byte_phase_q));
